/* rtl/bcs_pkg.sv */
// package: register map, reset values and types for the base clock selector
//
// What this block does
// - pll parameter writes are ignored while pll power is on
// - reference divider or feedback multiplier of 0 divides as 1
// - range multiplier 0 disables pll and forces oscillator source
// - source change holds output static, waiting up to three each clocks
// - switched clock is halved, bus clock is a quarter of source
// - halving bypass bit makes oscillator path skip the divide-by-two
// - base clock is osc, osc halved, or prescaled vco halved
// - vco source select refused while pll power is off
// - pll power-off refused while vco source is selected
// - one write cannot change both power and source select
// - pll reference clock is a buffered copy of oscillator clock
// - base clock output has 50 percent duty, twice bus rate
// - interrupt output is driven from the lock detector
// - reset clears source select, so halved oscillator drives output
// - reset sets pll power on so the loop settles at power-up
// - lock-change flag sets on lock toggle, clears on control read
package bcs_pkg;

  // ****************************************************************
  // register offsets (byte addresses, one word each)
  // ****************************************************************
  localparam logic [7:0] ADDR_PLL_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_BANDWIDTH = 8'h04;
  localparam logic [7:0] ADDR_MULT_HIGH = 8'h08;
  localparam logic [7:0] ADDR_MULT_LOW = 8'h0C;
  localparam logic [7:0] ADDR_VCO_RANGE = 8'h10;
  localparam logic [7:0] ADDR_REF_DIVIDER = 8'h14;
  localparam logic [7:0] ADDR_SYS_CONFIG = 8'h18;

  // ****************************************************************
  // control, bandwidth and system config register bit positions
  // ****************************************************************
  localparam int BIT_IRQ_ENABLE = 7;
  localparam int BIT_LOCK_FLAG = 6;
  localparam int BIT_POWER_ON = 5;
  localparam int BIT_SOURCE_SEL = 4;
  localparam int BIT_PRE_LO = 2;
  localparam int BIT_VPR_LO = 0;
  localparam int BIT_AUTO = 7;
  localparam int BIT_LOCK = 6;
  localparam int BIT_ACQ = 5;
  localparam int BIT_HALF_BYPASS = 0;
  localparam int BIT_OSC_UNHALVED = 1;

  // ****************************************************************
  // reset values and synchroniser depth
  // ****************************************************************
  localparam logic [11:0] RST_MULTIPLIER = 12'h040;
  localparam logic [7:0] RST_VCO_RANGE = 8'h40;
  localparam logic [3:0] RST_REF_DIVIDER = 4'h1;
  localparam logic [1:0] SYNC_STAGES = 2'h2;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic irqEnable;
    logic lockFlag;
    logic powerOn;
    logic sourceSel;
    logic [1:0] prescaleExp;
    logic [1:0] vcoRangeExp;
  } bcs_ctrl_t;

  typedef struct packed {
    logic [11:0] multiplier;
    logic [7:0] vcoRange;
    logic [3:0] refDivider;
  } bcs_params_t;

  typedef enum logic [1:0] {
    SRC_OSC_HALF,
    SRC_OSC_FULL,
    SRC_VCO_HALF
  } bcs_src_t;

endpackage

/* rtl/bcs_sync_gate.sv */
// module: two-flop select synchroniser and low-phase clock gate per domain
`timescale 1ns/10ps
module bcs_sync_gate (
  // own clock domain
  input wire logic clock,
  input wire logic rst,
  // request from the switching logic
  input wire logic wantOn,
  input wire logic otherOff,
  // state back to the switching logic
  output logic gateOn,
  output logic gateOff
);

  // ****************************************************************
  // synchroniser and gate flop
  // ****************************************************************
  logic syncMeta;
  logic syncStable;
  logic next_syncMeta;
  logic next_syncStable;
  logic next_gateOn;

  // enable only once the other domain is off: break before make
  always_comb begin
    next_syncMeta = wantOn & otherOff;
    next_syncStable = syncMeta;
    next_gateOn = syncStable;
  end

  // synchroniser on the rising edge of the domain clock
  always_ff @(posedge clock) begin
    if (rst) begin
      syncMeta <= 1'b0;
      syncStable <= 1'b0;
    end else begin
      syncMeta <= next_syncMeta;
      syncStable <= next_syncStable;
    end
  end

  // gate flop on the falling edge: the clock is low when it switches,
  // so closing the gate cannot cut a runt pulse
  always_ff @(negedge clock) begin
    if (rst) begin
      gateOn <= 1'b0;
    end else begin
      gateOn <= next_gateOn;
    end
  end

  assign gateOff = ~gateOn & ~syncStable;

endmodule

/* rtl/bcs_divider.sv */
// module: power-of-two prescaler producing the prescaled vco clock
`timescale 1ns/10ps
module bcs_divider #(
  parameter int WIDTH = 3
) (
  // vco domain
  input wire logic vcoClock,
  input wire logic rst,
  // programmed exponent
  input wire logic [1:0] exponent,
  // divided clock
  output logic divOut
);

  // ****************************************************************
  // ripple-free counter, tap chosen by exponent
  // ****************************************************************
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic next_divOut;

  always_comb begin
    next_count = count + WIDTH'(1);
    // exponent 0 is bypassed by the caller; the toggle keeps a defined value
    next_divOut = (exponent == 2'h0) ? ~divOut : next_count[exponent - 2'h1];
  end

  always_ff @(posedge vcoClock) begin
    if (rst) begin
      count <= '0;
      divOut <= 1'b0;
    end else begin
      count <= next_count;
      divOut <= next_divOut;
    end
  end

endmodule

/* rtl/bcs_clock_select.sv */
// module: base clock selector, pll control registers and wishbone slave
`timescale 1ns/10ps
module bcs_clock_select (
  // system clock and reset
  input wire logic clock,
  input wire logic rst,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // clock sources
  input wire logic oscClock,
  input wire logic vcoClock,
  // analog loop status
  input wire logic lockDetect,
  input wire logic acqDetect,
  // clock and control outputs
  output logic baseClockOut,
  output logic pllReferenceClock,
  output logic prescaledVcoClock,
  output logic pllEnable,
  output logic trackMode,
  output bcs_pkg::bcs_params_t pllParams,
  output logic [1:0] vcoRangeExponent,
  output logic lockChangeIrq
);

  // ****************************************************************
  // register state
  // ****************************************************************
  bcs_pkg::bcs_ctrl_t ctrl;
  bcs_pkg::bcs_ctrl_t next_ctrl;
  bcs_pkg::bcs_params_t params;
  bcs_pkg::bcs_params_t next_params;
  logic autoMode;
  logic next_autoMode;
  logic acqManual;
  logic next_acqManual;
  logic lockSeen;
  logic next_lockSeen;
  logic halvingBypass;
  logic next_halvingBypass;
  logic oscUnhalved;
  logic next_oscUnhalved;
  logic ack;
  logic next_ack;
  logic [31:0] rdData;
  logic [31:0] next_rdData;

  logic busAccess;
  logic wrEn;
  logic rdEn;
  logic [7:0] wrByte;
  logic pllBlocked;
  logic lockToggle;

  // byte 0 only; the 12-bit multiplier is split over two byte registers
  assign busAccess = wb_cyc_i & wb_stb_i & ~ack;
  assign wrEn = busAccess & wb_we_i & wb_sel_i[0];
  assign rdEn = busAccess & ~wb_we_i;
  assign wrByte = wb_dat_i[7:0];
  assign pllBlocked = (params.vcoRange == 8'h00);
  assign lockToggle = autoMode & (lockDetect != lockSeen);

  function automatic logic hit(input logic [7:0] a);
    hit = (wb_adr_i == a);
  endfunction

  // ****************************************************************
  // register next-state logic
  // ****************************************************************
  always_comb begin
    logic reqOn;
    logic reqSel;
    reqOn = 1'b0;
    reqSel = 1'b0;
    next_ctrl = ctrl;
    next_params = params;
    next_autoMode = autoMode;
    next_acqManual = acqManual;
    next_halvingBypass = halvingBypass;
    next_oscUnhalved = oscUnhalved;
    next_lockSeen = autoMode ? lockDetect : 1'b0;
    next_ack = busAccess;
    next_rdData = 32'h0000_0000;

    if (wrEn && hit(bcs_pkg::ADDR_PLL_CONTROL)) begin
      reqOn = wrByte[bcs_pkg::BIT_POWER_ON];
      reqSel = wrByte[bcs_pkg::BIT_SOURCE_SEL];
      if (autoMode) begin
        next_ctrl.irqEnable = wrByte[bcs_pkg::BIT_IRQ_ENABLE];
      end
      // both changing at once: neither takes effect
      if ((reqOn != ctrl.powerOn) && (reqSel != ctrl.sourceSel)) begin
      end else begin
        if (!(ctrl.sourceSel && !reqOn)) begin
          next_ctrl.powerOn = reqOn;
        end
        if (!(reqSel && (!ctrl.powerOn || pllBlocked))) begin
          next_ctrl.sourceSel = reqSel;
        end
      end
      if (!ctrl.powerOn) begin
        next_ctrl.prescaleExp = wrByte[bcs_pkg::BIT_PRE_LO +: 2];
        next_ctrl.vcoRangeExp = wrByte[bcs_pkg::BIT_VPR_LO +: 2];
      end
    end
    if (wrEn && hit(bcs_pkg::ADDR_BANDWIDTH)) begin
      next_autoMode = wrByte[bcs_pkg::BIT_AUTO];
      if (!autoMode) begin
        next_acqManual = wrByte[bcs_pkg::BIT_ACQ];
      end
    end
    if (wrEn && !ctrl.powerOn) begin
      if (hit(bcs_pkg::ADDR_MULT_HIGH)) begin
        next_params.multiplier[11:8] = wrByte[3:0];
      end
      if (hit(bcs_pkg::ADDR_MULT_LOW)) begin
        next_params.multiplier[7:0] = wrByte;
      end
      if (hit(bcs_pkg::ADDR_VCO_RANGE)) begin
        next_params.vcoRange = wrByte;
      end
      if (hit(bcs_pkg::ADDR_REF_DIVIDER)) begin
        next_params.refDivider = wrByte[3:0];
      end
    end
    if (wrEn && hit(bcs_pkg::ADDR_SYS_CONFIG)) begin
      next_halvingBypass = wrByte[bcs_pkg::BIT_HALF_BYPASS];
      next_oscUnhalved = wrByte[bcs_pkg::BIT_OSC_UNHALVED];
    end
    // an empty range field pulls the vco off the output
    if (pllBlocked) begin
      next_ctrl.sourceSel = 1'b0;
    end
    // manual mode keeps the enable and flag at zero
    if (!autoMode) begin
      next_ctrl.irqEnable = 1'b0;
    end

    if (rdEn) begin
      unique case (wb_adr_i)
        bcs_pkg::ADDR_PLL_CONTROL: next_rdData = {24'h000000, ctrl};
        bcs_pkg::ADDR_BANDWIDTH: next_rdData = {24'h000000, autoMode,
          autoMode & lockDetect, autoMode ? acqDetect : acqManual, 5'h00};
        bcs_pkg::ADDR_MULT_HIGH:
          next_rdData = {28'h0000000, params.multiplier[11:8]};
        bcs_pkg::ADDR_MULT_LOW:
          next_rdData = {24'h000000, params.multiplier[7:0]};
        bcs_pkg::ADDR_VCO_RANGE: next_rdData = {24'h000000, params.vcoRange};
        bcs_pkg::ADDR_REF_DIVIDER:
          next_rdData = {28'h0000000, params.refDivider};
        bcs_pkg::ADDR_SYS_CONFIG:
          next_rdData = {30'h00000000, oscUnhalved, halvingBypass};
        default: next_rdData = 32'h0000_0000;
      endcase
    end

    // a read clears the flag, but a toggle in the same cycle wins
    if (rdEn && hit(bcs_pkg::ADDR_PLL_CONTROL)) begin
      next_ctrl.lockFlag = 1'b0;
    end
    if (lockToggle) begin
      next_ctrl.lockFlag = 1'b1;
    end
    if (!autoMode) begin
      next_ctrl.lockFlag = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl <= '{irqEnable: 1'b0, lockFlag: 1'b0, powerOn: 1'b1,
                sourceSel: 1'b0, prescaleExp: 2'h0,
                vcoRangeExp: 2'h0};
      params <= '{multiplier: bcs_pkg::RST_MULTIPLIER,
                  vcoRange: bcs_pkg::RST_VCO_RANGE,
                  refDivider: bcs_pkg::RST_REF_DIVIDER};
      autoMode <= 1'b0;
      acqManual <= 1'b0;
      lockSeen <= 1'b0;
      halvingBypass <= 1'b0;
      oscUnhalved <= 1'b0;
      ack <= 1'b0;
      rdData <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      params <= next_params;
      autoMode <= next_autoMode;
      acqManual <= next_acqManual;
      lockSeen <= next_lockSeen;
      halvingBypass <= next_halvingBypass;
      oscUnhalved <= next_oscUnhalved;
      ack <= next_ack;
      rdData <= next_rdData;
    end
  end

  // ****************************************************************
  // registered control outputs
  // ****************************************************************
  bcs_pkg::bcs_params_t next_pllParams;
  logic next_pllEnable;
  logic next_irq;

  always_comb begin
    next_pllParams = params;
    // zero divides as one in the analog dividers
    if (params.multiplier == 12'h000) begin
      next_pllParams.multiplier = 12'h001;
    end
    if (params.refDivider == 4'h0) begin
      next_pllParams.refDivider = 4'h1;
    end
    next_pllEnable = ctrl.powerOn & ~pllBlocked;
    next_irq = ctrl.irqEnable & ctrl.lockFlag;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pllParams <= '0;
      pllEnable <= 1'b0;
      vcoRangeExponent <= 2'h0;
      trackMode <= 1'b0;
      lockChangeIrq <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      pllParams <= next_pllParams;
      pllEnable <= next_pllEnable;
      vcoRangeExponent <= ctrl.vcoRangeExp;
      trackMode <= autoMode ? acqDetect : acqManual;
      lockChangeIrq <= next_irq;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_rdData;
    end
  end

  // ****************************************************************
  // clock path: prescaler, break-before-make mux, halving stage
  // ****************************************************************
  // clocks here are generated in logic; a real chip would use cells
  logic pclkRaw;
  logic divClock;
  logic oscGateOn;
  logic oscGateOff;
  logic vcoGateOn;
  logic vcoGateOff;
  logic vcoWanted;
  logic muxClock;
  logic halfClock;
  logic next_halfClock;
  logic refBuf;
  logic next_baseClockOut;
  logic next_pclk;

  bcs_divider #(.WIDTH(3)) prescaler (
    .vcoClock(vcoClock),
    .rst(rst),
    .exponent(ctrl.prescaleExp),
    .divOut(divClock)
  );

  // exponent 0 divides by one: the vco clock itself
  assign pclkRaw = (ctrl.prescaleExp == 2'h0) ? vcoClock
    : divClock;

  assign vcoWanted = ctrl.sourceSel & pllEnable;

  bcs_sync_gate oscGate (
    .clock(oscClock),
    .rst(rst),
    .wantOn(~vcoWanted),
    .otherOff(vcoGateOff),
    .gateOn(oscGateOn),
    .gateOff(oscGateOff)
  );

  bcs_sync_gate vcoGate (
    .clock(pclkRaw),
    .rst(rst),
    .wantOn(vcoWanted),
    .otherOff(oscGateOff),
    .gateOn(vcoGateOn),
    .gateOff(vcoGateOff)
  );

  // output static while neither gate is open; during reset the oscillator
  // is let through so the halving flop sees edges and leaves its unknown
  assign muxClock = (oscGateOn & oscClock) | (vcoGateOn & pclkRaw)
    | (rst & oscClock);

  // halving stage restores 50 percent duty
  always_comb begin
    next_halfClock = ~halfClock;
  end

  always_ff @(posedge muxClock) begin
    if (rst) begin
      halfClock <= 1'b0;
    end else begin
      halfClock <= next_halfClock;
    end
  end

  // bypass only applies to the oscillator path
  always_comb begin
    if (oscGateOn && (halvingBypass || oscUnhalved)) begin
      next_baseClockOut = oscClock;
    end else begin
      next_baseClockOut = halfClock;
    end
    next_pclk = pclkRaw;
  end

  // reference buffer flop on both oscillator edges; base and prescaled clocks are not flopped
  always_ff @(posedge oscClock or negedge oscClock) begin
    refBuf <= oscClock;
  end

  assign pllReferenceClock = refBuf;
  assign baseClockOut = next_baseClockOut;
  assign prescaledVcoClock = next_pclk;

endmodule

/* testbench/bcs_clock_select_asserts.sv */
// checker: port-level properties of the base clock selector
`timescale 1ns/10ps
module bcs_clock_select_asserts (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // clocks and pll outputs
  input wire logic oscClock,
  input wire logic pllReferenceClock,
  input wire logic pllEnable,
  input wire bcs_pkg::bcs_params_t pllParams,
  input wire logic [1:0] vcoRangeExponent
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ****************************************************************
  // bus handshake
  // ****************************************************************
  ack_single_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_has_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  ack_latency_a: assert property ($rose(wb_cyc_i && wb_stb_i) |->
    ##[1:2] wb_ack_o) else $error("ack late");
  // ****************************************************************
  // clocks and pll control
  // ****************************************************************
  ref_clock_copy_a: assert property (pllReferenceClock == oscClock)
    else $error("reference clock differs from oscillator");
  reset_power_on_a: assert property ($fell(rst) |-> ##[1:2] pllEnable)
    else $error("pll not powered after reset");
  zero_div_as_one_a: assert property (!$past(rst) |->
    pllParams.multiplier != 12'h000 && pllParams.refDivider != 4'h0)
    else $error("zero divider reached the loop");
  zero_range_off_a: assert property (!$past(rst) &&
    pllParams.vcoRange == 8'h00 |-> !pllEnable)
    else $error("pll enabled with zero range");
  params_locked_a: assert property ($past(pllEnable) && pllEnable |->
    $stable(pllParams) && $stable(vcoRangeExponent))
    else $error("parameters changed while pll on");
endmodule

/* testbench/bcs_sim_model.sv */
// partner: system integration side counting base clock edges
`timescale 1ns/10ps
module bcs_sim_model (
  // base clock from the selector
  input wire logic baseClock,
  // window control from the bench
  input wire logic clearCount,
  input wire logic countEnable,
  // result
  output int edgeCount
);
  // bus clock is half of base, so every base rising edge is a half bus cycle
  always @(posedge baseClock or posedge clearCount) begin
    if (clearCount) begin
      edgeCount <= 0;
    end else if (countEnable) begin
      edgeCount <= edgeCount + 1;
    end
  end
endmodule

/* testbench/bcs_clock_select_tb.sv */
// testbench: self-checking bench for the base clock selector
`timescale 1ns/10ps
module bcs_clock_select_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic oscClock = 1'b0;
  logic vcoClock = 1'b0;
  logic lockDetect = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic ack;
  logic baseClock;
  logic pllEnable;
  logic irq;
  bcs_pkg::bcs_params_t params;
  logic clearCount = 1'b1;
  logic countEnable = 1'b0;
  int edgeCount;
  int mismatches = 0;
  int cmp_count = 0;
  // phases chosen so no source edge meets a system rising edge
  always #50 clock = ~clock;
  always #20 oscClock = ~oscClock;
  always #16 vcoClock = ~vcoClock;
  bcs_clock_select dut (.clock(clock), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .oscClock(oscClock),
    .vcoClock(vcoClock), .lockDetect(lockDetect), .acqDetect(1'b0),
    .baseClockOut(baseClock), .pllReferenceClock(), .prescaledVcoClock(),
    .pllEnable(pllEnable), .trackMode(), .pllParams(params),
    .vcoRangeExponent(), .lockChangeIrq(irq));
  bcs_sim_model sim (.baseClock(baseClock), .clearCount(clearCount),
    .countEnable(countEnable), .edgeCount(edgeCount));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h00000000);
    check(rd, e);
  endtask
  // count base clock edges over 60 system cycles, two edges of slack
  task automatic freq(input int e);
    repeat (10) @(posedge clock);
    clearCount <= 1'b0;
    countEnable <= 1'b1;
    repeat (60) @(posedge clock);
    countEnable <= 1'b0;
    @(posedge clock);
    check(32'(edgeCount >= e - 2 && edgeCount <= e + 2), 32'h00000001);
    clearCount <= 1'b1;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rchk(bcs_pkg::ADDR_PLL_CONTROL, 32'h00000020);
    rchk(bcs_pkg::ADDR_MULT_HIGH, 32'h00000000);
    rchk(bcs_pkg::ADDR_MULT_LOW, 32'h00000040);
    rchk(bcs_pkg::ADDR_VCO_RANGE, 32'h00000040);
    rchk(bcs_pkg::ADDR_REF_DIVIDER, 32'h00000001);
    rchk(8'h1C, 32'h00000000);
    wr(bcs_pkg::ADDR_MULT_LOW, 32'h00000055);
    rchk(bcs_pkg::ADDR_MULT_LOW, 32'h00000040);
    freq(75);
  endtask
  task automatic t_interlock();
    wr(bcs_pkg::ADDR_PLL_CONTROL, 32'h00000000);
    wr(bcs_pkg::ADDR_PLL_CONTROL, 32'h00000030);
    rchk(bcs_pkg::ADDR_PLL_CONTROL, 32'h00000000);
    wr(bcs_pkg::ADDR_PLL_CONTROL, 32'h00000010);
    rchk(bcs_pkg::ADDR_PLL_CONTROL, 32'h00000000);
    wr(bcs_pkg::ADDR_MULT_LOW, 32'h00000000);
    wr(bcs_pkg::ADDR_REF_DIVIDER, 32'h00000000);
    // outputs follow the register one edge later
    @(posedge clock);
    check(32'(params.multiplier), 32'h00000001);
    check(32'(params.refDivider), 32'h00000001);
    // range exponent 2, never 3: a 31.25 MHz vco sits in the top band
    wr(bcs_pkg::ADDR_PLL_CONTROL, 32'h00000006);
    wr(bcs_pkg::ADDR_VCO_RANGE, 32'h000000CB);
    rchk(bcs_pkg::ADDR_VCO_RANGE, 32'h000000CB);
    wr(bcs_pkg::ADDR_PLL_CONTROL, 32'h00000026);
    wr(bcs_pkg::ADDR_PLL_CONTROL, 32'h00000036);
    wr(bcs_pkg::ADDR_PLL_CONTROL, 32'h00000016);
    rchk(bcs_pkg::ADDR_PLL_CONTROL, 32'h00000036);
    // vco 32 ns, prescaled 64 ns, halved 128 ns: 47 edges in 6000 ns
    freq(47);
    wr(bcs_pkg::ADDR_PLL_CONTROL, 32'h00000026);
    freq(75);
  endtask
  task automatic t_zero_range();
    wr(bcs_pkg::ADDR_PLL_CONTROL, 32'h00000006);
    wr(bcs_pkg::ADDR_VCO_RANGE, 32'h00000000);
    wr(bcs_pkg::ADDR_PLL_CONTROL, 32'h00000026);
    @(posedge clock);
    check(32'(pllEnable), 32'h00000000);
    wr(bcs_pkg::ADDR_PLL_CONTROL, 32'h00000036);
    rchk(bcs_pkg::ADDR_PLL_CONTROL, 32'h00000026);
    wr(bcs_pkg::ADDR_PLL_CONTROL, 32'h00000006);
    wr(bcs_pkg::ADDR_VCO_RANGE, 32'h000000CB);
    wr(bcs_pkg::ADDR_PLL_CONTROL, 32'h00000026);
    @(posedge clock);
    check(32'(pllEnable), 32'h00000001);
  endtask
  task automatic t_osc_modes();
    wr(bcs_pkg::ADDR_SYS_CONFIG, 32'h00000002);
    freq(150);
    wr(bcs_pkg::ADDR_SYS_CONFIG, 32'h00000001);
    freq(150);
    wr(bcs_pkg::ADDR_SYS_CONFIG, 32'h00000000);
  endtask
  task automatic t_lock_irq();
    int n;
    wr(bcs_pkg::ADDR_BANDWIDTH, 32'h00000080);
    wr(bcs_pkg::ADDR_PLL_CONTROL, 32'h000000A6);
    @(posedge clock);
    lockDetect <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (irq !== 1'b1 && n < 10);
    check(32'(irq), 32'h00000001);
    rchk(bcs_pkg::ADDR_PLL_CONTROL, 32'h000000E6);
    repeat (3) @(posedge clock);
    check(32'(irq), 32'h00000000);
    wr(bcs_pkg::ADDR_PLL_CONTROL, 32'h00000026);
    lockDetect <= 1'b0;
    repeat (5) @(posedge clock);
    check(32'(irq), 32'h00000000);
    rchk(bcs_pkg::ADDR_PLL_CONTROL, 32'h00000066);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_interlock();
    t_zero_range();
    t_osc_modes();
    t_lock_irq();
    print_verdict();
  end
endmodule
bind bcs_clock_select bcs_clock_select_asserts chk (.clock(clock), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .oscClock(oscClock), .pllReferenceClock(pllReferenceClock),
  .pllEnable(pllEnable), .pllParams(pllParams),
  .vcoRangeExponent(vcoRangeExponent));
